// ### bench/tb_top.sv
// self-checking bench for the two-wire slave: master model on the bus pins
// assumes the slave holds its own fifo and synchronisers; open-drain sda here
`timescale 1ns/1ns
`default_nettype none
`include "tws_params.svh"
module tb_top;
    logic        sys_clk = 1'b0;
    logic        rst_n;
    logic        scl;
    logic        m_pull;
    logic        sda_oe;
    logic        sda_o;
    logic [2:0]  sel;
    logic        rx_valid;
    logic        rx_ready;
    logic [7:0]  rx_data;
    logic        tx_take;
    logic        busy;
    logic        selected;
    logic        reading;
    logic [1:0]  tx_idx;
    logic [7:0]  tx_tab [4] = '{8'hA5, 8'h3C, 8'h81, 8'h00};
    wire logic   sda_line;
    int          fails = 0;
    int          checks_done = 0;

    assign sda_line = ~m_pull & (~sda_oe | sda_o);

    always #50 sys_clk = ~sys_clk;

    // next transmit byte is presented once the slave has taken the current one
    always @(negedge sys_clk) begin
        if (tx_take === 1'b1) begin
            tx_idx <= tx_idx + 2'h1;
        end
    end

    tws_master_model bus_master (.scl_o(scl), .sda_pull_o(m_pull), .sda_i(sda_line));

    tws_slave dut (
        .sys_clk_i           (sys_clk),
        .rst_n_i             (rst_n),
        .scl_i               (scl),
        .sda_i               (sda_line),
        .sda_o               (sda_o),
        .sda_oe_o            (sda_oe),
        .addr_select_pin_0_i (sel[0]),
        .addr_select_pin_1_i (sel[1]),
        .addr_select_pin_2_i (sel[2]),
        .rx_valid_o          (rx_valid),
        .rx_ready_i          (rx_ready),
        .rx_data_o           (rx_data),
        .tx_data_i           (tx_tab[tx_idx]),
        .tx_take_o           (tx_take),
        .busy_o              (busy),
        .selected_o          (selected),
        .reading_o           (reading)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // takes n bytes from the receive stream and expects base, base+1, ...
    task automatic drain(input int n, input logic [7:0] base);
        int w;
        @(negedge sys_clk) rx_ready = 1'b1;
        for (int i = 0; i < n; i++) begin
            w = 0;
            while (rx_valid !== 1'b1 && w < 20) begin
                w++;
                @(negedge sys_clk);
            end
            check("rx_data", rx_data, base + i[7:0]);
            @(negedge sys_clk);
        end
        @(negedge sys_clk) rx_ready = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("rx_empty", rx_valid, 1'b0);
    endtask

    task automatic end_transfer();
        bus_master.stop();
        #500 check("busy_after_stop", busy, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // every strap setting: matching control acked, a mismatch ignored
    task automatic t_addr();
        logic       a;
        logic [7:0] bad;
        for (int s = 0; s < 8; s++) begin
            @(negedge sys_clk) sel = s[2:0];
            bus_master.start();
            check("busy_after_start", busy, 1'b1);
            bus_master.wr_byte({`TWS_DEV_TYPE, s[2:0], 1'b0}, a);
            check("ctrl_ack", a, 1'b1);
            end_transfer();
            bad = (s == 7) ? {`TWS_DEV_TYPE ^ 4'h8, s[2:0], 1'b0}
                           : {`TWS_DEV_TYPE, s[2:0] ^ (3'h1 << (s % 3)), 1'b0};
            bus_master.start();
            bus_master.wr_byte(bad, a);
            check("bad_ctrl_ack", a, 1'b0);
            bus_master.wr_byte(8'h00, a);
            check("ignored_byte_ack", a, 1'b0);
            check("not_selected", selected, 1'b0);
            end_transfer();
        end
    endtask

    // stalled consumer: bytes acked until the buffer is full, then drained
    task automatic t_fill();
        logic a;
        int   n;
        n = 0;
        @(negedge sys_clk) sel = 3'h5;
        bus_master.start();
        bus_master.wr_byte({`TWS_DEV_TYPE, 3'h5, 1'b0}, a);
        check("wr_ctrl_ack", a, 1'b1);
        check("wr_selected", selected, 1'b1);
        check("wr_direction", reading, 1'b0);
        a = 1'b1;
        for (int k = 0; k < 8 && a; k++) begin
            bus_master.wr_byte(8'h10 + k[7:0], a);
            n = a ? n + 1 : n;
        end
        check("fill_count", n[7:0], 8'h05);
        check("full_refused", a, 1'b0);
        end_transfer();
        drain(n, 8'h10);
    endtask

    // slave transmitter: master acks two bytes and refuses the third
    task automatic t_read();
        logic       a;
        logic [7:0] d;
        @(negedge sys_clk) tx_idx = 2'h0;
        bus_master.start();
        bus_master.wr_byte({`TWS_DEV_TYPE, 3'h5, 1'b1}, a);
        check("rd_ctrl_ack", a, 1'b1);
        check("rd_direction", reading, 1'b1);
        bus_master.rd_byte(1'b1, d);
        check("rd_byte0", d, 8'hA5);
        bus_master.rd_byte(1'b1, d);
        check("rd_byte1", d, 8'h3C);
        bus_master.rd_byte(1'b0, d);
        check("rd_byte2", d, 8'h81);
        #500 check("released_after_nack", sda_oe, 1'b0);
        end_transfer();
    endtask

    // write one byte, then turn round with a repeated start and read
    task automatic t_rstart();
        logic       a;
        logic [7:0] d;
        @(negedge sys_clk) sel = 3'h2;
        tx_idx = 2'h0;
        bus_master.start();
        bus_master.wr_byte({`TWS_DEV_TYPE, 3'h2, 1'b0}, a);
        bus_master.wr_byte(8'h5A, a);
        check("rs_data_ack", a, 1'b1);
        bus_master.start();
        bus_master.wr_byte({`TWS_DEV_TYPE, 3'h2, 1'b1}, a);
        check("rs_ctrl_ack", a, 1'b1);
        check("rs_direction", reading, 1'b1);
        bus_master.rd_byte(1'b0, d);
        check("rs_rd_byte", d, 8'hA5);
        end_transfer();
        drain(1, 8'h5A);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n    = 1'b0;
        rx_ready = 1'b0;
        sel      = 3'h0;
        tx_idx   = 2'h0;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk) rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("busy_idle", busy, 1'b0);
        t_addr();
        t_fill();
        t_read();
        t_rstart();
        tally_and_finish();
    end

    // whole run is well under 1 ms of bus time
    initial begin
        #2000000;
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ### bench/tws_master_model.sv
// behavioural two-wire bus master: makes scl, start, stop and every bit cycle
// assumes sda_i is the resolved wire with a pull-up and nothing else drives scl
`timescale 1ns/1ns
`default_nettype none
module tws_master_model (
    output logic      scl_o,
    output logic      sda_pull_o,
    input  wire logic sda_i
);
    // both lines released: the bus idles high and scl stands still
    initial begin
        scl_o      = 1'b1;
        sda_pull_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // start or repeated start; the long wait before scl rises lets an ack driver let go
    task automatic start();
        #13 sda_pull_o = 1'b0;
        #500 scl_o = 1'b1;
        #400 sda_pull_o = 1'b1;
        #400 scl_o = 1'b0;
    endtask

    task automatic stop();
        #200 sda_pull_o = 1'b1;
        #200 scl_o = 1'b1;
        #400 sda_pull_o = 1'b0;
        #400;
    endtask

    // one clock pulse per bit, sda moved only while scl is low
    task automatic bit_cycle(input logic drv, output logic seen);
        #200 sda_pull_o = ~drv;
        #200 scl_o = 1'b1;
        #200 seen = sda_i;
        #200 scl_o = 1'b0;
    endtask

    task automatic wr_byte(input logic [7:0] b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], s);
        end
        bit_cycle(1'b1, s);
        acked = ~s;
    endtask

    task automatic rd_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 0; i < 8; i++) begin
            bit_cycle(1'b1, s);
            b = {b[6:0], s};
        end
        bit_cycle(~ack, s);
    endtask
endmodule
`default_nettype wire

// ### logic/tws_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module tws_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    tws_stream_if.snk             wr,
    output logic                  rd_valid_o,
    input  wire logic             rd_ready_i,
    output logic [WIDTH-1:0]      rd_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      rp_q;
    logic             full;
    logic             empty;
    assign full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty = (wp_q == rp_q);
    assign wr.ready   = !full;
    assign rd_valid_o = !empty;
    assign rd_data_o  = mem_q[rp_q[AW-1:0]];

    always_ff @(posedge sys_clk_i) begin
        if (wr.valid && !full) begin
            mem_q[wp_q[AW-1:0]] <= wr.data;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_q <= '0;
        end else if (wr.valid && !full) begin
            wp_q <= wp_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rp_q <= '0;
        end else if (rd_ready_i && !empty) begin
            rp_q <= rp_q + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### logic/tws_params.svh
// constants for the two-wire slave interface
// assumes a 10 MHz system clock and the scl/sda pins sampled through synchronisers
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// device-type code: value is arbitrary
`define TWS_DEV_TYPE      4'hA
`define TWS_CTRL_TYPE_HI  7
`define TWS_CTRL_TYPE_LO  4
`define TWS_CTRL_SEL_HI   3
`define TWS_CTRL_SEL_LO   1
`define TWS_CTRL_DIR_BIT  0
`define TWS_BIT_LAST      3'h7
`define TWS_FIFO_DEPTH    4
`define TWS_FIFO_WIDTH    8
`define TWS_SYS_CLK_KHZ   10000
`define TWS_FAST_SCL_KHZ  400
`define TWS_STD_SCL_KHZ   100
`define TWS_MIN_HALF_CYC  ((`TWS_SYS_CLK_KHZ / `TWS_FAST_SCL_KHZ) / 2)
`define TWS_IDLE_BYTE     8'hFF

`endif

// ### logic/tws_pkg.sv
// types shared by the two-wire slave interface modules
// assumes nothing beyond a SystemVerilog compiler
package tws_pkg;

    typedef enum logic [2:0] {
        TWS_IDLE  = 3'b000,
        TWS_RX    = 3'b001,
        TWS_ACK   = 3'b010,
        TWS_TX    = 3'b011,
        TWS_MACK  = 3'b100,
        TWS_WAIT  = 3'b101
    } tws_state_type;

endpackage

// ### logic/tws_slave.sv
// two-wire bus slave: start/stop detection, control byte match, rx and tx bytes
// assumes scl and sda are open-drain pins resolved outside; address pins static
`timescale 1ns/1ns
`default_nettype none
`include "tws_params.svh"
module tws_slave
    import tws_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic       addr_select_pin_0_i,
    input  wire logic       addr_select_pin_1_i,
    input  wire logic       addr_select_pin_2_i,
    output logic            rx_valid_o,
    input  wire logic       rx_ready_i,
    output logic [7:0]      rx_data_o,
    input  wire logic [7:0] tx_data_i,
    output logic            tx_take_o,
    output logic            busy_o,
    output logic            selected_o,
    output logic            reading_o
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    logic scl_s;
    logic sda_s;
    logic scl_p_q;
    logic sda_p_q;
    logic [2:0] sel_s;
    logic [2:0] sel_q;

    tws_sync u_sync_scl (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (scl_i),
        .sync_o    (scl_s)
    );
    tws_sync u_sync_sda (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (sda_i),
        .sync_o    (sda_s)
    );

    genvar gi;
    logic [2:0] sel_raw;
    assign sel_raw = {addr_select_pin_2_i, addr_select_pin_1_i, addr_select_pin_0_i};
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sel
            tws_sync #(.RST_VAL(1'b0)) u_sync_sel (
                .sys_clk_i (sys_clk_i),
                .rst_n_i   (rst_n_i),
                .async_i   (sel_raw[gi]),
                .sync_o    (sel_s[gi])
            );
        end
    endgenerate

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            sel_q   <= 3'h0;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            sel_q   <= sel_s;
        end
    end

    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic scl_fall_raw;
    logic scl_hi_seen_q;
    // sampling at 10 MHz gives at least 12 samples per 400 kHz half period
    assign start_det    = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_det     = scl_s && scl_p_q && !sda_p_q && sda_s;
    assign scl_rise     = scl_s && !scl_p_q;
    assign scl_fall_raw = !scl_s && scl_p_q;
    // the fall that closes a start is not a bit: only count falls after a rise
    assign scl_fall     = scl_fall_raw && scl_hi_seen_q;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_hi_seen_q <= 1'b0;
        end else if (start_det || scl_fall_raw) begin
            scl_hi_seen_q <= 1'b0;
        end else if (scl_rise) begin
            scl_hi_seen_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit and byte sequencing
    tws_state_type state_q;
    logic [2:0]    bit_q;
    logic [7:0]    shift_q;
    logic          first_q;
    logic          dir_q;
    logic          mack_q;
    logic          ctrl_match;

    assign ctrl_match = (shift_q[`TWS_CTRL_TYPE_HI:`TWS_CTRL_TYPE_LO] == `TWS_DEV_TYPE)
                     && (shift_q[`TWS_CTRL_SEL_HI:`TWS_CTRL_SEL_LO] == sel_q);

    // a stream into the fifo carries every acked data byte
    tws_stream_if rx_if ();
    logic rx_push_q;
    assign rx_if.valid = rx_push_q;
    assign rx_if.data  = shift_q;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= TWS_IDLE;
        end else if (start_det) begin
            state_q <= TWS_RX;
        end else if (stop_det) begin
            state_q <= TWS_IDLE;
        end else begin
            unique case (state_q)
                TWS_IDLE: begin
                    state_q <= TWS_IDLE;
                end
                TWS_RX: begin
                    if (scl_fall && bit_q == `TWS_BIT_LAST) begin
                        if (first_q && !ctrl_match) begin
                            state_q <= TWS_WAIT;
                        end else if (!first_q && !rx_if.ready) begin
                            state_q <= TWS_WAIT;
                        end else begin
                            state_q <= TWS_ACK;
                        end
                    end
                end
                TWS_ACK: begin
                    if (scl_fall) begin
                        state_q <= dir_q ? TWS_TX : TWS_RX;
                    end
                end
                TWS_TX: begin
                    if (scl_fall && bit_q == `TWS_BIT_LAST) begin
                        state_q <= TWS_MACK;
                    end
                end
                TWS_MACK: begin
                    if (scl_fall) begin
                        state_q <= mack_q ? TWS_WAIT : TWS_TX;
                    end
                end
                TWS_WAIT: begin
                    state_q <= TWS_WAIT;
                end
                default: begin
                    state_q <= TWS_IDLE;
                end
            endcase
        end
    end

    // bit counter counts scl falls; wraps per byte so bytes are unlimited
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_q <= 3'h0;
        end else if (start_det) begin
            bit_q <= 3'h0;
        end else if (scl_fall && (state_q == TWS_RX || state_q == TWS_TX)) begin
            bit_q <= bit_q + 3'h1;
        end else if (state_q == TWS_ACK || state_q == TWS_MACK) begin
            bit_q <= 3'h0;
        end
    end

    // receive shifts on scl rise, transmit shifts after each bit fall
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_q <= 8'h00;
        end else if (state_q == TWS_RX && scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
        end else if (state_q == TWS_ACK && scl_fall && dir_q) begin
            shift_q <= tx_data_i;
        end else if (state_q == TWS_MACK && scl_fall) begin
            shift_q <= tx_data_i;
        end else if (state_q == TWS_TX && scl_fall) begin
            shift_q <= {shift_q[6:0], 1'b1};
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_q <= 1'b0;
            dir_q   <= 1'b0;
        end else if (start_det) begin
            first_q <= 1'b1;
            dir_q   <= 1'b0;
        end else if (state_q == TWS_RX && scl_fall && bit_q == `TWS_BIT_LAST && first_q) begin
            dir_q   <= shift_q[`TWS_CTRL_DIR_BIT];
        end else if (state_q == TWS_ACK && scl_fall) begin
            first_q <= 1'b0;
        end
    end

    // master ack sampled on scl rise of the ninth pulse
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mack_q <= 1'b0;
        end else if (state_q == TWS_MACK && scl_rise) begin
            mack_q <= sda_s;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_push_q <= 1'b0;
        end else begin
            rx_push_q <= state_q == TWS_RX && scl_fall && bit_q == `TWS_BIT_LAST
                         && !first_q && rx_if.ready && !start_det && !stop_det;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_take_o <= 1'b0;
        end else begin
            tx_take_o <= scl_fall
                         && ((state_q == TWS_ACK && dir_q) || (state_q == TWS_MACK && !mack_q))
                         && !start_det && !stop_det;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sda drive: changes only follow an scl fall, so sda is steady while scl is high
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_oe_o <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe_o <= 1'b0;
        end else if (scl_fall) begin
            unique case (state_q)
                TWS_RX: begin
                    sda_oe_o <= bit_q == `TWS_BIT_LAST
                                && (first_q ? ctrl_match : rx_if.ready);
                end
                TWS_ACK: begin
                    sda_oe_o <= dir_q && !tx_data_i[7];
                end
                TWS_TX: begin
                    sda_oe_o <= bit_q != `TWS_BIT_LAST && !shift_q[6];
                end
                TWS_MACK: begin
                    sda_oe_o <= !mack_q && !tx_data_i[7];
                end
                default: begin
                    sda_oe_o <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status and receive fifo
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_o     <= 1'b0;
            selected_o <= 1'b0;
            reading_o  <= 1'b0;
        end else begin
            busy_o     <= state_q != TWS_IDLE;
            selected_o <= state_q == TWS_ACK || state_q == TWS_TX || state_q == TWS_MACK
                          || (state_q == TWS_RX && !first_q);
            reading_o  <= dir_q && state_q != TWS_IDLE && state_q != TWS_WAIT;
        end
    end

    logic       fifo_valid;
    logic [7:0] fifo_data;
    logic       fifo_pop;
    assign fifo_pop = fifo_valid && (!rx_valid_o || rx_ready_i);

    tws_fifo #(.WIDTH(`TWS_FIFO_WIDTH), .DEPTH(`TWS_FIFO_DEPTH)) u_fifo (
        .sys_clk_i  (sys_clk_i),
        .rst_n_i    (rst_n_i),
        .wr         (rx_if),
        .rd_valid_o (fifo_valid),
        .rd_ready_i (fifo_pop),
        .rd_data_o  (fifo_data)
    );

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_valid_o <= 1'b0;
            rx_data_o  <= 8'h00;
        end else if (fifo_pop) begin
            rx_valid_o <= 1'b1;
            rx_data_o  <= fifo_data;
        end else if (rx_ready_i) begin
            rx_valid_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_START_RX: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        start_det |=> state_q == TWS_RX && first_q && bit_q == 3'h0)
        else $error("start not taken as transfer start");
    AST_STOP_IDLE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        stop_det && !start_det |=> state_q == TWS_IDLE && !sda_oe_o)
        else $error("stop did not end transfer");
    AST_SDA_STEADY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        scl_s && scl_p_q && !start_det && !stop_det |=> $stable(sda_oe_o))
        else $error("sda drive changed while scl high");
    AST_ACK_HELD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        state_q == TWS_ACK && scl_s && !start_det && !stop_det |-> sda_oe_o)
        else $error("ack not held low during scl high");
    AST_NACK_RELEASE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        state_q == TWS_MACK && scl_fall && mack_q |=> !sda_oe_o && state_q == TWS_WAIT)
        else $error("sda not released after master nack");
    AST_MISMATCH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        state_q == TWS_WAIT |-> !sda_oe_o)
        else $error("sda driven while deselected");
    AST_CTRL_ACK: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        state_q == TWS_RX && first_q && scl_fall && bit_q == 3'h7 && !ctrl_match
        && !start_det && !stop_det |=> !sda_oe_o)
        else $error("acked a foreign control byte");
    AST_RX_PUSH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        state_q == TWS_ACK && !first_q && !dir_q && $rose(state_q == TWS_ACK)
        |-> rx_push_q)
        else $error("received byte not pushed");
    AST_READ_DIR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        state_q == TWS_ACK && scl_fall && dir_q && !start_det && !stop_det
        |=> state_q == TWS_TX)
        else $error("read direction did not enter transmit");
endmodule
`default_nettype wire

// ### logic/tws_stream_if.sv
// stream carrier between the slave core and its fifo
// assumes both ends on sys_clk
`timescale 1ns/1ns
`default_nettype none
interface tws_stream_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### logic/tws_sync.sv
// two-flop synchroniser for one level
// assumes the input is asynchronous to sys_clk
`timescale 1ns/1ns
`default_nettype none
module tws_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta_q;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule
`default_nettype wire
